// ---- kpi_key_model.sv ----
// kpi_key_model: keys and outside signals on the eight port pins
// assumes pad controls from the unit; pins move after clk_sys edges
`timescale 1ns/1ps
module kpi_key_model
  import kpi_pkg::*;
(
  input wire logic clk_sys,
  input wire kpi_pad_s pad,
  input wire logic [7:0] press,
  input wire logic [7:0] lvl,
  output logic [7:0] pin_in = 8'hFF
);
  // pressed keys drive their level, released pins follow pull or wander
  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      if (press[i]) pin_in[i] <= lvl[i];
      else if (pad.pull_down[i]) pin_in[i] <= 1'b0;
      else if (pad.pull_enable[i]) pin_in[i] <= 1'b1;
      else pin_in[i] <= ~pin_in[i];
    end
  end
endmodule : kpi_key_model

// ---- kpi_keyboard_pin_interrupt.sv ----
// kpi_keyboard_pin_interrupt: eight-pin keyboard interrupt with ahb-lite regs
// assumes pins already synchronous to clk_sys; one clock, synchronous reset
//
// Notes on behaviour
// - each pin enable bit connects its pin to detection; zero leaves gpio.
// - enabled keyboard pins are forced to inputs whatever the direction bit.
// - pins 3..0 always detect falling edges or low levels.
// - pins 7..4 polarity bits: 0 falling/low, 1 rising/high.
// - high pins enabled with rising polarity get pulldown instead of pullup.
// - an enabled keyboard interrupt wakes the core from wait and stop.
// - read-only pending flag bit 3 sets on trigger at any enabled pin.
// - acknowledge bit 2 is write-only, reads 0, writing 1 clears flag.
// - edge-and-level mode keeps flag set while any enabled pin is asserted.
// - interrupt enable bit 1 requests interrupt while flag is set.
// - mode bit 0 selects edge-only, 1 selects edge-and-level.
// - edge found when pin sampled deasserted then asserted next cycle.
// - enabled inputs must sit deasserted before an edge can be detected.
// - in stop, edge logic bypassed; asserted enabled pins set wake at the next clk_sys edge.
`timescale 1ns/1ps
module kpi_keyboard_pin_interrupt
  import kpi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pin_in,
  output kpi_pad_s pad,
  output logic [7:0] port_a_data,
  output logic kbd_irq,
  output logic wake,
  output logic evt_irq
);
  logic [7:0] keyboard_pin_enable;
  logic [3:0] polarity_select;
  logic detection_mode;
  logic interrupt_request_enable;
  logic pending_flag;
  logic [7:0] port_a_direction;
  logic [7:0] port_pull_enable;
  kpi_power_e power;
  logic [KPI_EV_W-1:0] ev_status;
  logic [KPI_EV_W-1:0] ev_mask;
  logic [7:0] pin_prev;
  logic armed;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] active_high;
  logic [7:0] asserted;
  logic [7:0] prev_asserted;
  logic edge_hit;
  logic level_hit;
  logic ack_wr;
  logic next_pending;
  logic [31:0] next_rdata;
  logic [7:0] next_pull_down;
  logic [7:0] next_pull_enable;

  // per-pin polarity: low four fixed falling/low, high four selectable
  assign active_high = {polarity_select, 4'h0};
  assign asserted = keyboard_pin_enable & (pin_in ~^ active_high);
  assign prev_asserted = keyboard_pin_enable & (pin_prev ~^ active_high);
  // edge: deasserted last cycle, asserted now, and edge logic armed (not in stop)
  assign edge_hit = armed && |(asserted & ~prev_asserted);
  assign level_hit = detection_mode && |asserted;
  assign ph_valid = hsel && hready && htrans[1];
  assign wr_stb = ph_valid && hwrite;
  assign rd_stb = ph_valid && !hwrite;
  assign ack_wr = ph_write && ph_addr == KPI_ADDR_STATUS_CONTROL
                  && hwdata[KPI_BIT_ACK];

  // address phase capture; zero-wait, always okay
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph_write <= 1'b0;
      ph_addr <= KPI_BYTE_RESET;
    end else begin
      ph_write <= wr_stb;
      ph_addr <= haddr[7:0];
    end
  end

  // control register writes in the data phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      keyboard_pin_enable <= KPI_BYTE_RESET;
      polarity_select <= KPI_BYTE_RESET[3:0];
      detection_mode <= 1'b0;
      interrupt_request_enable <= 1'b0;
      port_a_direction <= KPI_BYTE_RESET;
      port_pull_enable <= KPI_BYTE_RESET;
      ev_mask <= KPI_EV_RESET;
      power <= KPI_RUN;
    end else begin
      if (ph_write) begin
        case (ph_addr)
          KPI_ADDR_STATUS_CONTROL: begin
            polarity_select <= hwdata[KPI_POL_MSB:KPI_POL_LSB];
            interrupt_request_enable <= hwdata[KPI_BIT_IE];
            detection_mode <= hwdata[KPI_BIT_MODE];
          end
          KPI_ADDR_PIN_ENABLE: keyboard_pin_enable <= hwdata[7:0];
          KPI_ADDR_PORT_CONTROL: begin
            port_a_direction <= hwdata[KPI_PORT_DIR_LSB +: 8];
            port_pull_enable <= hwdata[KPI_PORT_PULL_LSB +: 8];
            if (hwdata[KPI_BIT_STOP]) begin
              power <= KPI_STOP;
            end else if (hwdata[KPI_BIT_WAIT]) begin
              power <= KPI_WAIT;
            end
          end
          KPI_ADDR_EVENT_MASK: ev_mask <= hwdata[KPI_EV_W-1:0];
          default: ;
        endcase
      end
      // any asserted enabled pin or pending request ends low power
      if (power != KPI_RUN && (|asserted || (pending_flag
          && interrupt_request_enable))) begin
        power <= KPI_RUN;
      end
    end
  end

  // pending flag: set wins over acknowledge, level holds it set
  always_comb begin
    next_pending = pending_flag;
    if (ack_wr) begin
      next_pending = 1'b0;
    end
    if (edge_hit || level_hit) begin
      next_pending = 1'b1;
    end
  end

  // input history keeps sampling; stop bypasses edges by clearing armed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pending_flag <= 1'b0;
      pin_prev <= KPI_BYTE_RESET;
      armed <= 1'b0;
    end else begin
      pending_flag <= next_pending;
      pin_prev <= pin_in;
      armed <= (power != KPI_STOP);
    end
  end

  // sticky events, cleared by a read of the event status register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev_status <= KPI_EV_RESET;
    end else begin
      if (rd_stb && haddr[7:0] == KPI_ADDR_EVENT_STATUS) begin
        ev_status <= KPI_EV_RESET;
      end
      if (next_pending && !pending_flag) begin
        ev_status[KPI_EV_FLAG] <= 1'b1;
      end
      if (power != KPI_RUN && |asserted) begin
        ev_status[KPI_EV_WAKE] <= 1'b1;
      end
    end
  end

  // read mux; acknowledge reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      KPI_ADDR_STATUS_CONTROL: begin
        next_rdata[KPI_POL_MSB:KPI_POL_LSB] = polarity_select;
        next_rdata[KPI_BIT_FLAG] = next_pending;
        next_rdata[KPI_BIT_ACK] = 1'b0;
        next_rdata[KPI_BIT_IE] = interrupt_request_enable;
        next_rdata[KPI_BIT_MODE] = detection_mode;
      end
      KPI_ADDR_PIN_ENABLE: next_rdata[7:0] = keyboard_pin_enable;
      KPI_ADDR_PORT_CONTROL: begin
        next_rdata[KPI_PORT_DIR_LSB +: 8] = port_a_direction;
        next_rdata[KPI_PORT_PULL_LSB +: 8] = port_pull_enable;
        next_rdata[KPI_BIT_WAIT] = (power == KPI_WAIT);
        next_rdata[KPI_BIT_STOP] = (power == KPI_STOP);
      end
      KPI_ADDR_EVENT_STATUS: next_rdata[KPI_EV_W-1:0] = ev_status;
      KPI_ADDR_EVENT_MASK: next_rdata[KPI_EV_W-1:0] = ev_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // pull devices: pulldown on enabled high pins with rising polarity
  always_comb begin
    next_pull_down = keyboard_pin_enable & active_high;
    next_pull_enable = port_pull_enable
                       & (~port_a_direction | keyboard_pin_enable);
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pad <= '0;
      port_a_data <= KPI_BYTE_RESET;
      kbd_irq <= 1'b0;
      wake <= 1'b0;
      evt_irq <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_stb) begin
        hrdata <= next_rdata;
      end
      pad.out_enable <= port_a_direction & ~keyboard_pin_enable;
      pad.pull_enable <= next_pull_enable;
      pad.pull_down <= next_pull_down;
      port_a_data <= pin_in & ~keyboard_pin_enable;
      kbd_irq <= next_pending && interrupt_request_enable;
      wake <= (power != KPI_RUN) && (|asserted
              || (next_pending && interrupt_request_enable));
      evt_irq <= |(ev_status & ev_mask);
    end
  end

  // flag follows an edge in one cycle
  property p_edge_sets;
    @(posedge clk_sys) disable iff (rst)
      edge_hit |=> pending_flag;
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set pending flag");

  property p_ack_clears;
    @(posedge clk_sys) disable iff (rst)
      (ack_wr && !edge_hit && !level_hit) |=> !pending_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear flag");

  property p_level_holds;
    @(posedge clk_sys) disable iff (rst)
      (detection_mode && |asserted) |=> pending_flag;
  endproperty
  a_level_holds: assert property (p_level_holds)
    else $error("asserted level did not hold flag");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      ##1 kbd_irq == $past(next_pending && interrupt_request_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request mismatch");

  property p_edge_only;
    @(posedge clk_sys) disable iff (rst)
      (!detection_mode && !edge_hit && !pending_flag) |=> !pending_flag;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("flag set without edge in edge-only mode");

  property p_forced_input;
    @(posedge clk_sys) disable iff (rst)
      ##1 (pad.out_enable & $past(keyboard_pin_enable)) == 8'h00;
  endproperty
  a_forced_input: assert property (p_forced_input)
    else $error("keyboard pin driven as output");

  property p_pulldown;
    @(posedge clk_sys) disable iff (rst)
      ##1 pad.pull_down[3:0] == 4'h0;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pulldown on a low-order pin");

  property p_stop_no_edge;
    @(posedge clk_sys) disable iff (rst)
      (power == KPI_STOP) ##1 (power == KPI_STOP) |-> !armed;
  endproperty
  a_stop_no_edge: assert property (p_stop_no_edge)
    else $error("edge logic active in stop");

  property p_rd_ack_zero;
    @(posedge clk_sys) disable iff (rst)
      (rd_stb && haddr[7:0] == KPI_ADDR_STATUS_CONTROL)
        |=> !hrdata[KPI_BIT_ACK];
  endproperty
  a_rd_ack_zero: assert property (p_rd_ack_zero)
    else $error("acknowledge bit read as one");
endmodule : kpi_keyboard_pin_interrupt

// ---- kpi_pkg.sv ----
// kpi_pkg: constants and carrier types for the keyboard pin interrupt unit
// assumes a 32-bit ahb-lite slave with word-aligned registers
package kpi_pkg;
  localparam int KPI_PINS = 8;
  // register byte addresses
  localparam logic [7:0] KPI_ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] KPI_ADDR_PIN_ENABLE = 8'h04;
  localparam logic [7:0] KPI_ADDR_PORT_CONTROL = 8'h08;
  localparam logic [7:0] KPI_ADDR_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] KPI_ADDR_EVENT_MASK = 8'h10;
  // status/control field positions
  localparam int KPI_BIT_MODE = 0;
  localparam int KPI_BIT_IE = 1;
  localparam int KPI_BIT_ACK = 2;
  localparam int KPI_BIT_FLAG = 3;
  localparam int KPI_POL_LSB = 4;
  localparam int KPI_POL_MSB = 7;
  // port control: general-purpose direction, pull enable, low-power modes
  localparam int KPI_PORT_DIR_LSB = 0;
  localparam int KPI_PORT_PULL_LSB = 8;
  localparam int KPI_BIT_WAIT = 16;
  localparam int KPI_BIT_STOP = 17;
  // event status bits
  localparam int KPI_EV_FLAG = 0;
  localparam int KPI_EV_WAKE = 1;
  localparam int KPI_EV_W = 2;
  localparam logic [7:0] KPI_BYTE_RESET = 8'h00;
  localparam logic [KPI_EV_W-1:0] KPI_EV_RESET = 2'h0;
  localparam logic [1:0] KPI_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] KPI_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {KPI_RUN, KPI_WAIT, KPI_STOP} kpi_power_e;

  // pad controls handed to the port
  typedef struct packed {
    logic [7:0] out_enable;
    logic [7:0] pull_enable;
    logic [7:0] pull_down;
  } kpi_pad_s;
endpackage : kpi_pkg

// ---- test_keyboard_pin_interrupt.sv ----
// test_keyboard_pin_interrupt: bus and key scenarios for the unit
// assumes kpi_pkg and kpi_key_model; one 200 MHz clock, sync reset
`timescale 1ns/1ps
module test_keyboard_pin_interrupt
  import kpi_pkg::*;
;
  logic clk_sys, hreadyout, hresp, kbd_irq, wake, evt_irq;
  logic rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = KPI_HSIZE_WORD;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0] pin_in, port_a_data, press = 8'h0, lvl = 8'h0;
  kpi_pad_s pad;
  int errors = 0, checked = 0;
  kpi_keyboard_pin_interrupt uut (.clk_sys, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .pin_in, .pad, .port_a_data, .kbd_irq, .wake, .evt_irq);
  kpi_key_model keys (.clk_sys, .pad, .press, .lvl, .pin_in);
  // free-running bus clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // wait for hready at a rising edge, bounded
  task automatic rdy;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) return;
    end
    chk("hready", 32'h1, 32'h0);
    test_done();
  endtask : rdy
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= KPI_HTRANS_NONSEQ;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  // bounded wait for kbd_irq (s=0) or wake (s=1) to reach v
  task automatic sig(input bit s, input logic v);
    int n;
    for (n = 0; n < 40 && (s ? wake : kbd_irq) !== v; n++)
      @(posedge clk_sys);
    chk(s ? "wake" : "kbd_irq", 32'(v), 32'(s ? wake : kbd_irq));
    if (n == 40) test_done();
  endtask : sig
  task automatic key(input logic [7:0] p, l);
    @(posedge clk_sys);
    press <= p;
    lvl <= l;
  endtask : key
  // reset, then the scenarios in order
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("status", KPI_ADDR_STATUS_CONTROL, 32'h0);
    rdc("enable", KPI_ADDR_PIN_ENABLE, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("hresp", 32'h0, 32'(hresp));
    $display("test reset done");
    // pull the pins up before enabling them so they sit deasserted
    wr(KPI_ADDR_PORT_CONTROL, 32'hFF00);
    wr(KPI_ADDR_PIN_ENABLE, 32'h0F);
    wr(KPI_ADDR_PORT_CONTROL, 32'hFFFF);
    rdc("enable", KPI_ADDR_PIN_ENABLE, 32'h0F);
    chk("out_enable", 32'hF0, 32'(pad.out_enable));
    chk("pull_enable", 32'h0F, 32'(pad.pull_enable));
    wr(KPI_ADDR_PORT_CONTROL, 32'hFF00);
    wr(KPI_ADDR_STATUS_CONTROL, 32'h06);
    wr(KPI_ADDR_EVENT_MASK, 32'h1);
    bus(1'b0, KPI_ADDR_EVENT_STATUS, 32'h0);
    key(8'h01, 8'h00);
    sig(0, 1'b1);
    rdc("flag", KPI_ADDR_STATUS_CONTROL, 32'h0A);
    chk("evt_irq", 32'h1, 32'(evt_irq));
    rdc("event", KPI_ADDR_EVENT_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("evt_irq", 32'h0, 32'(evt_irq));
    wr(KPI_ADDR_STATUS_CONTROL, 32'h06);
    rdc("ack", KPI_ADDR_STATUS_CONTROL, 32'h02);
    sig(0, 1'b0);
    key(8'h00, 8'h00);
    $display("test edge done");
    wr(KPI_ADDR_STATUS_CONTROL, 32'h01);
    key(8'h02, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk("polled", 32'h0, 32'(kbd_irq));
    wr(KPI_ADDR_STATUS_CONTROL, 32'h05);
    rdc("held", KPI_ADDR_STATUS_CONTROL, 32'h09);
    key(8'h00, 8'h00);
    repeat (4) @(posedge clk_sys);
    wr(KPI_ADDR_STATUS_CONTROL, 32'h05);
    rdc("freed", KPI_ADDR_STATUS_CONTROL, 32'h01);
    $display("test level done");
    wr(KPI_ADDR_STATUS_CONTROL, 32'hF2);
    wr(KPI_ADDR_PIN_ENABLE, 32'h11);
    rdc("polarity", KPI_ADDR_STATUS_CONTROL, 32'hF2);
    chk("pull_down", 32'h10, 32'(pad.pull_down));
    chk("port_a_data", 32'hEE, 32'(port_a_data));
    key(8'h01, 8'h00);
    sig(0, 1'b1);
    wr(KPI_ADDR_STATUS_CONTROL, 32'hF6);
    key(8'h00, 8'h00);
    sig(0, 1'b0);
    wr(KPI_ADDR_EVENT_MASK, 32'h0);
    key(8'h02, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk("kbd_irq", 32'h0, 32'(kbd_irq));
    key(8'h10, 8'h10);
    sig(0, 1'b1);
    chk("masked", 32'h0, 32'(evt_irq));
    wr(KPI_ADDR_STATUS_CONTROL, 32'hF6);
    key(8'h00, 8'h00);
    sig(0, 1'b0);
    $display("test polarity done");
    for (int m = 16; m < 18; m++) begin
      wr(KPI_ADDR_PORT_CONTROL, 32'hFF00 | (32'h1 << m));
      key(8'h01, 8'h00);
      sig(1, 1'b1);
      key(8'h00, 8'h00);
      sig(1, 1'b0);
      wr(KPI_ADDR_STATUS_CONTROL, 32'hF6);
    end
    rdc("event", KPI_ADDR_EVENT_STATUS, 32'h3);
    $display("test power done");
    test_done();
  end
endmodule : test_keyboard_pin_interrupt
